// file: verilog/dsclk_top.sv
// Double-speed clock selection: speed registers on APB, halving stage,
// glitch-free global mode switch and core/peripheral cycle strobes.
// Assumes ref_clk_i is oscillator A and the security byte bit is stable at reset.
//
// The APB register port is this design's own decision.
module dsclk_top
    import dsclk_pkg::*;
#(
    parameter int unsigned ADDR_W = DSCLK_ADDR_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic security_config_byte_dbl_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic osc_half_o,
    output logic core_clk_en_o,
    output logic machine_cycle_o,
    output logic [DSCLK_CNT_W-1:0] machine_phase_o,
    output logic double_speed_sel_o,
    output dsclk_periph_t periph_fast_o,
    output dsclk_periph_t periph_tick_o
);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic hit_speed;
    logic hit_speed2;
    logic hit_status;
    logic hit_any;
    logic wr_low_byte;

    assign setup_phase = psel_i && !penable_i;
    assign access_phase = psel_i && penable_i;
    assign hit_speed = (paddr_i == ADDR_W'(dsclk_byte_addr(DSCLK_IDX_SPEED)));
    assign hit_speed2 = (paddr_i == ADDR_W'(dsclk_byte_addr(DSCLK_IDX_SPEED2)));
    assign hit_status = (paddr_i == ADDR_W'(dsclk_byte_addr(DSCLK_IDX_STATUS)));
    assign hit_any = hit_speed || hit_speed2 || hit_status;
    // Registers are byte wide; only lane 0 carries a write
    assign wr_low_byte = access_phase && pwrite_i && pstrb_i[0];

    // Read data is sampled in the setup cycle so prdata_o comes from a flop
    assign pready_o = access_phase;
    assign pslverr_o = access_phase && !hit_any;

    // ------------------------------------------------------------------
    // Speed registers
    // ------------------------------------------------------------------
    logic [7:0] speed_q, speed_d;
    logic [7:0] speed2_q, speed2_d;

    always_comb begin
        speed_d = speed_q;
        speed2_d = speed2_q;
        if (wr_low_byte && hit_speed) begin
            speed_d = pwdata_i[7:0];
        end
        if (wr_low_byte && hit_speed2) begin
            // Reserved bits are not stored and read back as zero
            speed2_d = DSCLK_SPEED2_RST;
            speed2_d[DSCLK_BIT_SPI] = pwdata_i[DSCLK_BIT_SPI];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            // Upper bits clear, global bit loaded from the security byte
            speed_q <= DSCLK_SPEED_RST;
            speed_q[DSCLK_BIT_GLOBAL] <= security_config_byte_dbl_i;
            speed2_q <= DSCLK_SPEED2_RST;
        end else begin
            speed_q <= speed_d;
            speed2_q <= speed2_d;
        end
    end

    // ------------------------------------------------------------------
    // Halving stage and global mode switch
    // ------------------------------------------------------------------
    logic half_q, half_d;
    dsclk_mode_t mode_q, mode_d;
    logic half_rise;
    logic dbl_active;

    // The halved clock rises on the edge where half_q goes from 0 to 1
    assign half_rise = !half_q;
    assign dbl_active = (mode_q == DSCLK_MODE_FAST);

    always_comb begin
        half_d = !half_q;
        mode_d = mode_q;
        // Software bit is only sampled as the halved clock rises
        if (half_rise) begin
            case (mode_q)
                DSCLK_MODE_SLOW: begin
                    if (speed_q[DSCLK_BIT_GLOBAL]) begin
                        mode_d = DSCLK_MODE_FAST;
                    end
                end
                DSCLK_MODE_FAST: begin
                    if (!speed_q[DSCLK_BIT_GLOBAL]) begin
                        mode_d = DSCLK_MODE_SLOW;
                    end
                end
                default: begin
                    mode_d = DSCLK_MODE_SLOW;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            half_q <= 1'b0;
            mode_q <= security_config_byte_dbl_i ? DSCLK_MODE_FAST : DSCLK_MODE_SLOW;
        end else begin
            half_q <= half_d;
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // Core clock enable and machine cycle
    // ------------------------------------------------------------------
    logic core_en_q, core_en_d;

    always_comb begin
        // Raw oscillator in double speed, every other period in standard
        if (mode_d == DSCLK_MODE_FAST) begin
            core_en_d = 1'b1;
        end else begin
            core_en_d = half_rise;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            core_en_q <= 1'b0;
        end else begin
            core_en_q <= core_en_d;
        end
    end

    // Machine cycle: 6 periods in double speed, 12 in standard
    dsclk_phase_gen #(
        .SLOW_LEN(DSCLK_PERIODS_SLOW),
        .FAST_LEN(DSCLK_PERIODS_FAST),
        .CNT_W(DSCLK_CNT_W)
    ) u_core_cycle (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .fast_i(dbl_active),
        .tick_o(machine_cycle_o),
        .phase_o(machine_phase_o)
    );

    // ------------------------------------------------------------------
    // Peripheral speed selection
    // ------------------------------------------------------------------
    dsclk_periph_t sel_bits;
    dsclk_periph_t fast_d;
    dsclk_periph_t fast_q;
    dsclk_periph_t tick_vec;

    // Raw control bits gathered per peripheral
    always_comb begin
        sel_bits.twowire = speed_q[DSCLK_BIT_TWOWIRE];
        sel_bits.wdog = speed_q[DSCLK_BIT_WDOG];
        sel_bits.pca = speed_q[DSCLK_BIT_PCA];
        sel_bits.uart = speed_q[DSCLK_BIT_UART];
        sel_bits.timer2 = speed_q[DSCLK_BIT_TIMER2];
        sel_bits.timer1 = speed_q[DSCLK_BIT_TIMER1];
        sel_bits.timer0 = speed_q[DSCLK_BIT_TIMER0];
        sel_bits.spi = speed2_q[DSCLK_BIT_SPI];
    end

    // Cleared bit means fast, but only while double speed is in force
    always_comb begin
        if (dbl_active) begin
            fast_d = ~sel_bits;
        end else begin
            fast_d = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            fast_q <= '0;
        end else begin
            fast_q <= fast_d;
        end
    end

    // One strobe generator per peripheral clock
    for (genvar i = 0; i < $bits(dsclk_periph_t); i++) begin : g_periph
        dsclk_phase_gen #(
            .SLOW_LEN(DSCLK_PERIODS_SLOW),
            .FAST_LEN(DSCLK_PERIODS_FAST),
            .CNT_W(DSCLK_CNT_W)
        ) u_periph_cycle (
            .ref_clk_i(ref_clk_i),
            .resetn_i(resetn_i),
            .fast_i(fast_q[i]),
            .tick_o(tick_vec[i]),
            .phase_o()
        );
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (setup_phase && !pwrite_i) begin
            rdata_d = 32'h00000000;
            if (hit_speed) begin
                rdata_d[7:0] = speed_q;
            end else if (hit_speed2) begin
                rdata_d[7:0] = speed2_q;
            end else if (hit_status) begin
                rdata_d[0] = dbl_active;
                rdata_d[8:1] = fast_q;
                rdata_d[9] = half_q;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata_o = rdata_q;
    assign osc_half_o = half_q;
    assign core_clk_en_o = core_en_q;
    assign double_speed_sel_o = dbl_active;
    assign periph_fast_o = fast_q;
    assign periph_tick_o = tick_vec;

endmodule // dsclk_top

// file: shared/dsclk_pkg.sv
// Constants, types and register map of the double-speed clock selection block.
// Assumes one 100 MHz oscillator A clock and an APB master for the registers.
//
// How it works
// - In double-speed mode a machine cycle lasts 6 oscillator periods.
// - Standard mode halves oscillator A for core and peripherals; software can bypass it.
// - Double-speed mode bypasses the halving stage; the raw oscillator drives the core.
// - A global speed change is applied only at a rising edge of the halved clock.
// - Control bit 0 is the global speed bit: set gives 6 periods, clear 12.
// - Reset clears control bits 7..1 and loads bit 0 from the security byte.
// - Peripheral speed bits act only while the global speed bit is set.
// - Cleared peripheral bit gives 6 periods per cycle, set bit gives 12.
// - Bit 7 two-wire, bit 6 watchdog, bit 5 counter array speed.
// - Bit 4 UART modes 0 and 2; bits 3, 2, 1 timers 2, 1, 0.
// - Control register sits at index 8Fh and is accessed as a whole byte.
// - The SPI speed bit lives in a second control register, same qualification.
// - Second register at index AFh: bit 0 SPI speed, rest reserved, resets zero.
package dsclk_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] DSCLK_IDX_SPEED = 8'h8F;
    localparam logic [7:0] DSCLK_IDX_SPEED2 = 8'hAF;
    localparam logic [7:0] DSCLK_IDX_STATUS = 8'hB0;
    localparam int unsigned DSCLK_ADDR_W = 12;

    // Field positions in the speed registers; the SPI bit is in the second one
    localparam int unsigned DSCLK_BIT_GLOBAL = 0;
    localparam int unsigned DSCLK_BIT_TIMER0 = 1;
    localparam int unsigned DSCLK_BIT_TIMER1 = 2;
    localparam int unsigned DSCLK_BIT_TIMER2 = 3;
    localparam int unsigned DSCLK_BIT_UART = 4;
    localparam int unsigned DSCLK_BIT_PCA = 5;
    localparam int unsigned DSCLK_BIT_WDOG = 6;
    localparam int unsigned DSCLK_BIT_TWOWIRE = 7;
    localparam int unsigned DSCLK_BIT_SPI = 0;

    // Reset values; bit 0 of the main register comes from the security byte
    localparam logic [7:0] DSCLK_SPEED_RST = 8'h00;
    localparam logic [7:0] DSCLK_SPEED2_RST = 8'h00;

    // Oscillator periods per machine or peripheral cycle
    localparam int unsigned DSCLK_PERIODS_SLOW = 12;
    localparam int unsigned DSCLK_PERIODS_FAST = 6;
    localparam int unsigned DSCLK_CNT_W = 4;

    // Core speed state, one-hot
    typedef enum logic [1:0] {
        DSCLK_MODE_SLOW = 2'b01,
        DSCLK_MODE_FAST = 2'b10
    } dsclk_mode_t;

    // One bit per peripheral clock
    typedef struct packed {
        logic spi;
        logic twowire;
        logic wdog;
        logic pca;
        logic uart;
        logic timer2;
        logic timer1;
        logic timer0;
    } dsclk_periph_t;

    function automatic logic [DSCLK_ADDR_W-1:0] dsclk_byte_addr(input logic [7:0] idx);
        dsclk_byte_addr = {2'h0, idx, 2'h0};
    endfunction

endpackage

// file: verilog/dsclk_phase_gen.sv
// Cycle strobe generator: one pulse every 6 or 12 oscillator periods.
// Assumes fast_i is a registered level; a new length applies at the next wrap.
module dsclk_phase_gen
    import dsclk_pkg::*;
#(
    parameter int unsigned SLOW_LEN = DSCLK_PERIODS_SLOW,
    parameter int unsigned FAST_LEN = DSCLK_PERIODS_FAST,
    parameter int unsigned CNT_W = DSCLK_CNT_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic fast_i,
    output logic tick_o,
    output logic [CNT_W-1:0] phase_o
);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] last_q, last_d;
    logic tick_q, tick_d;

    // Length is latched only at the end of a cycle so no cycle is cut short
    always_comb begin
        cnt_d = cnt_q + CNT_W'(1);
        last_d = last_q;
        tick_d = 1'b0;
        if (cnt_q == last_q) begin
            cnt_d = '0;
            tick_d = 1'b1;
            last_d = fast_i ? CNT_W'(FAST_LEN - 1) : CNT_W'(SLOW_LEN - 1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            last_q <= CNT_W'(SLOW_LEN - 1);
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            last_q <= last_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
    assign phase_o = cnt_q;

endmodule // dsclk_phase_gen

// file: dv/dsclk_top_assertions.sv
// Concurrent checks on the ports of the double-speed clock block.
// Assumes one clock domain and the fixed APB map of the block.
module dsclk_chk
    import dsclk_pkg::*;
#(
    parameter int unsigned ADDR_W = DSCLK_ADDR_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic osc_half_o,
    input wire logic core_clk_en_o,
    input wire logic machine_cycle_o,
    input wire logic [DSCLK_CNT_W-1:0] machine_phase_o,
    input wire logic double_speed_sel_o,
    input wire dsclk_periph_t periph_fast_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic acc;
    logic mapped;
    assign acc = psel_i && penable_i;
    assign mapped = paddr_i == ADDR_W'({DSCLK_IDX_SPEED, 2'h0})
        || paddr_i == ADDR_W'({DSCLK_IDX_SPEED2, 2'h0})
        || paddr_i == ADDR_W'({DSCLK_IDX_STATUS, 2'h0});
    sequence s_gap6;
        !machine_cycle_o [*5] ##1 machine_cycle_o;
    endsequence
    sequence s_gap12;
        !machine_cycle_o [*6] ##1 !machine_cycle_o [*5] ##1 machine_cycle_o;
    endsequence
    a_pready_access: assert property (pready_o == acc)
        else $error("pready not tied to access phase");
    a_err_unmapped: assert property (acc |-> pslverr_o == !mapped)
        else $error("pslverr wrong for address");
    a_half_toggle: assert property ($past(resetn_i) |-> osc_half_o != $past(osc_half_o))
        else $error("halved clock did not toggle");
    a_mode_on_rise: assert property ($past(resetn_i) && $changed(double_speed_sel_o)
        |-> !$past(osc_half_o)) else $error("mode switched off halved clock rise");
    a_periph_gated: assert property ($past(resetn_i) && !double_speed_sel_o
        && !$past(double_speed_sel_o) |-> periph_fast_o == '0)
        else $error("peripheral fast bit active in standard mode");
    a_core_bypass: assert property ($past(resetn_i, 2) && double_speed_sel_o
        && $past(double_speed_sel_o, 2) |-> core_clk_en_o)
        else $error("core enable missing in double speed");
    a_fast_len: assert property (machine_cycle_o && double_speed_sel_o
        && $past(double_speed_sel_o) |=> s_gap6) else $error("fast machine cycle not 6");
    a_slow_len: assert property (machine_cycle_o && !double_speed_sel_o
        && !$past(double_speed_sel_o) |=> s_gap12) else $error("standard cycle not 12");
    a_core_half: assert property ($past(resetn_i) && !double_speed_sel_o
        |-> core_clk_en_o == osc_half_o) else $error("core enable not on halved clock rise");
    a_phase_wrap: assert property (machine_cycle_o |-> machine_phase_o == '0)
        else $error("machine phase not zero at cycle start");
    a_phase_count: assert property ($past(resetn_i) && !machine_cycle_o
        |-> machine_phase_o == DSCLK_CNT_W'($past(machine_phase_o) + 1))
        else $error("machine phase did not advance");
endmodule // dsclk_chk

bind dsclk_top dsclk_chk #(.ADDR_W(ADDR_W)) chk_u (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .osc_half_o(osc_half_o),
    .core_clk_en_o(core_clk_en_o), .machine_cycle_o(machine_cycle_o),
    .machine_phase_o(machine_phase_o),
    .double_speed_sel_o(double_speed_sel_o), .periph_fast_o(periph_fast_o));

// file: dv/dsclk_apb_host.sv
// APB master standing in for the CPU software.
// Assumes ref_clk_i is the block's oscillator clock.
module dsclk_apb_host (
    input wire logic ref_clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {psel_o, penable_o, pwrite_o} = 3'h0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
        pstrb_o = 4'h0;
    end
    // Holds the request until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] v,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge ref_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= {24'h0, v};
        pstrb_o <= s;
        @(posedge ref_clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule // dsclk_apb_host

// file: dv/dsclk_top_tb_top.sv
// Self-checking bench for the double-speed clock block.
// Assumes the hand-over timing: mode settles within 3 edges of a write.
module dsclk_top_tb_top
    import dsclk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_SPD = {2'h0, DSCLK_IDX_SPEED, 2'h0};
    localparam logic [11:0] A_SP2 = {2'h0, DSCLK_IDX_SPEED2, 2'h0};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic sec_bit = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    dsclk_periph_t pfast, ptick;
    logic mcyc;
    logic [8:0] tk;
    int error_cnt = 0;
    int tests_run = 0;
    assign tk = {ptick, mcyc};
    dsclk_top dut_u (.ref_clk_i(ref_clk), .resetn_i(resetn), .security_config_byte_dbl_i(sec_bit),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .osc_half_o(), .core_clk_en_o(), .machine_cycle_o(mcyc),
        .machine_phase_o(), .double_speed_sel_o(), .periph_fast_o(pfast), .periph_tick_o(ptick));
    dsclk_apb_host host_u (.ref_clk_i(ref_clk), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic bad(input logic [31:0] got);
        error_cnt++;
        $display("mismatch at %0t: got %h", $time, got);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
        logic [31:0] d;
        logic e;
        host_u.xfer(1'b1, a, v, s, d, e);
    endtask
    task automatic chk_reg(input logic [11:0] a, input logic [7:0] exp, input logic eerr);
        logic [31:0] d;
        logic e;
        host_u.xfer(1'b0, a, 8'h00, 4'h0, d, e);
        tests_run++;
        if (d !== {24'h0, exp} || e !== eerr) bad(d);
    endtask
    task automatic chk_fast(input logic [7:0] exp);
        repeat (4) @(posedge ref_clk);
        tests_run++;
        if (pfast !== exp) bad(32'(pfast));
    endtask
    // Distance between the last two strobes on tk[i]
    task automatic chk_len(input int i, input int exp);
        int k, r;
        for (r = 0; r < 3; r++) begin
            k = 0;
            do begin
                @(posedge ref_clk);
                k++;
            end while (tk[i] !== 1'b1 && k < 30);
        end
        tests_run++;
        if (k != exp) bad(k);
    endtask
    task automatic do_reset(input logic s);
        sec_bit <= s;
        resetn <= 1'b0;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    initial begin
        int i;
        do_reset(1'b0);
        chk_reg(A_SPD, 8'h00, 1'b0);
        chk_reg(A_SP2, 8'h00, 1'b0);
        chk_reg(12'h004, 8'h00, 1'b1);
        chk_len(0, 12);
        wr(A_SPD, 8'h01, 4'hF);
        chk_reg(A_SPD, 8'h01, 1'b0);
        chk_fast(8'hFF);
        for (i = 0; i < 9; i++) chk_len(i, 6);
        // Each peripheral bit of the main register in turn, global bit kept set
        for (i = 1; i < 8; i++) begin
            wr(A_SPD, 8'h01 | (8'h01 << i), 4'hF);
            chk_fast(8'hFF & ~(8'h01 << (i - 1)));
        end
        chk_len(7, 12);
        wr(A_SP2, 8'hFF, 4'hF);
        chk_reg(A_SP2, 8'h01, 1'b0);
        chk_fast(8'h3F);
        wr(A_SPD, 8'hFE, 4'hF);
        chk_fast(8'h00);
        chk_len(1, 12);
        chk_len(0, 12);
        wr(A_SPD, 8'h01, 4'h0);
        chk_reg(A_SPD, 8'hFE, 1'b0);
        do_reset(1'b1);
        chk_reg(A_SPD, 8'h01, 1'b0);
        chk_reg(A_SP2, 8'h00, 1'b0);
        chk_len(0, 6);
        close_out();
    end
endmodule // dsclk_top_tb_top
